// [core/board_regs.svh]
// register indices, field positions and reset values of the board register group
`ifndef BOARD_REGS_SVH
`define BOARD_REGS_SVH

// --------------------------------------------------------------
// register indices; byte address is four times the index
// --------------------------------------------------------------
`define IDX_SERIAL_CTRL 10'h283
`define IDX_DEV_PROTECT 10'h284
`define IDX_RESET_CAUSE 10'h285
`define IDX_IRQ_ROUTE 10'h286
`define IDX_REAR_IO 10'h287

// --------------------------------------------------------------
// field positions
// --------------------------------------------------------------
`define BIT_SYS_MIRROR 7
`define BIT_SSD 2
`define BIT_EEPROM 1
`define BIT_BOOT 0
`define BIT_COLD 7
`define BIT_PANEL 2
`define BIT_BACKPLANE 1
`define BIT_WATCHDOG 0
`define BIT_UART_EN 7
`define BIT_PFAIL_EN 6
`define BIT_ENUM_EN 5
`define BIT_DERATE_EN 4
`define WD_ROUTE_HI 1
`define WD_ROUTE_LO 0
`define REAR_HI 5
`define REAR_LO 4
`define BIT_SERIAL_A 2

// --------------------------------------------------------------
// reset values and encodings
// --------------------------------------------------------------
`define RST_PROTECT 3'h0
`define RST_CAUSE 3'h0
`define RST_COLD 1'h1
`define RST_UART_EN 1'h1
`define RST_SRC_EN 3'h0
`define RST_WD_ROUTE 2'h0
`define WD_ROUTE_IRQ5 2'h1
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [core/board_pkg.sv]
// types shared by the board register group
package board_pkg;
	typedef logic [7:0] reg_byte_t;
	typedef logic [1:0] axi_resp_t;
	typedef logic [1:0] wd_route_t;
	typedef logic [1:0] rear_cfg_t;
	typedef logic [2:0] protect_t;
endpackage : board_pkg

// [core/board_protect_reset_irq_regs.sv]
// board protect, reset cause, interrupt routing and rear i/o register group
//
// Operation
// - protect bit 7 mirrors active-low system protect
// - ssd protect bit 2 set-only latch
// - eeprom protect bit 1 set-only latch
// - boot flash protect bit 0 set-only latch
// - cold flag set at power-on, write-one clears
// - panel reset flag, write-one clears, resets 0
// - backplane reset flag, write-one clears, resets 0
// - watchdog reset flag, write-one clears, resets 0
// - only power-on reset restores reset cause flags
// - bit 7 enables uart irq3/irq4, resets 1
// - bit 6 routes power fail to irq5
// - bit 5 routes enumeration to irq5
// - bit 4 routes derating to irq5
// - bits 1:0 route watchdog, 01 to irq5
// - status bits 5:4 report rear i/o straps
// - serial a route reset depends on build
// - control bit 2 selects serial a route
`timescale 1ns/1ps
`include "board_regs.svh"

module board_protect_reset_irq_regs #(
	parameter int ADDR_W = 12,
	parameter bit FRONT_IO_BUILD = 1'b0
) (
	input wire logic CORE_CLK_I,
	input wire logic RST_I,
	input wire logic WARM_RST_I,
	input wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
	input wire logic S_AXI_AWVALID_I,
	output logic S_AXI_AWREADY_O,
	input wire logic [31:0] S_AXI_WDATA_I,
	input wire logic [3:0] S_AXI_WSTRB_I,
	input wire logic S_AXI_WVALID_I,
	output logic S_AXI_WREADY_O,
	output board_pkg::axi_resp_t S_AXI_BRESP_O,
	output logic S_AXI_BVALID_O,
	input wire logic S_AXI_BREADY_I,
	input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
	input wire logic S_AXI_ARVALID_I,
	output logic S_AXI_ARREADY_O,
	output logic [31:0] S_AXI_RDATA_O,
	output board_pkg::axi_resp_t S_AXI_RRESP_O,
	output logic S_AXI_RVALID_O,
	input wire logic S_AXI_RREADY_I,
	input wire logic SYS_PROTECT_N_I,
	input wire logic PANEL_RESET_I,
	input wire logic BACKPLANE_RESET_I,
	input wire logic WATCHDOG_RESET_I,
	input wire logic POWER_FAIL_N_I,
	input wire logic ENUM_N_I,
	input wire logic DERATE_N_I,
	input wire board_pkg::rear_cfg_t REAR_IO_CONFIG_I,
	input wire logic UART_IRQ3_I,
	input wire logic UART_IRQ4_I,
	input wire logic WATCHDOG_IRQ_I,
	output logic SSD_PROTECT_O,
	output logic EEPROM_PROTECT_O,
	output logic BOOT_FLASH_PROTECT_O,
	output logic IRQ3_O,
	output logic IRQ4_O,
	output logic IRQ5_O,
	output logic SERIAL_A_ROUTE_O
);
	import board_pkg::*;

	// --------------------------------------------------------------
	// elaboration checks
	// --------------------------------------------------------------
	if (ADDR_W < 12 || ADDR_W > 32) begin : g_bad_addr_w
		$error("ADDR_W must lie in 12..32");
	end

	// --------------------------------------------------------------
	// pin synchronisers
	// --------------------------------------------------------------
	localparam int NSYNC = 10;
	localparam int S_SYSP = 0;
	localparam int S_PANEL = 1;
	localparam int S_BPRST = 2;
	localparam int S_WDRST = 3;
	localparam int S_PFAIL = 4;
	localparam int S_ENUM = 5;
	localparam int S_DERATE = 6;
	localparam int S_REAR0 = 7;
	localparam int S_REAR1 = 8;
	localparam int S_WARM = 9;
	// active-low pins idle high so nothing looks asserted at reset
	localparam logic [NSYNC-1:0] SYNC_RST = 10'h071;

	logic [NSYNC-1:0] pin_raw;
	logic [NSYNC-1:0] sync1_q;
	logic [NSYNC-1:0] sync2_q;

	assign pin_raw = {WARM_RST_I, REAR_IO_CONFIG_I[1], REAR_IO_CONFIG_I[0],
		DERATE_N_I, ENUM_N_I, POWER_FAIL_N_I, WATCHDOG_RESET_I,
		BACKPLANE_RESET_I, PANEL_RESET_I, SYS_PROTECT_N_I};

	for (genvar g = 0; g < NSYNC; g++) begin : g_sync
		always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
			if (RST_I) begin
				sync1_q[g] <= SYNC_RST[g];
				sync2_q[g] <= SYNC_RST[g];
			end else begin
				sync1_q[g] <= pin_raw[g];
				sync2_q[g] <= sync1_q[g];
			end
		end
	end

	wire warm = sync2_q[S_WARM];
	wire sys_protect_mirror = ~sync2_q[S_SYSP];
	wire power_fail_in = ~sync2_q[S_PFAIL];
	wire enum_in = ~sync2_q[S_ENUM];
	wire derate_in = ~sync2_q[S_DERATE];
	wire backplane_reset_in = sync2_q[S_BPRST];
	rear_cfg_t rear_io_config;
	assign rear_io_config = {sync2_q[S_REAR1], sync2_q[S_REAR0]};

	// --------------------------------------------------------------
	// axi write channel
	// --------------------------------------------------------------
	logic aw_full_q;
	logic w_full_q;
	logic awready_q;
	logic wready_q;
	logic bvalid_q;
	axi_resp_t bresp_q;
	logic [ADDR_W-3:0] aw_idx_q;
	reg_byte_t wdata_q;
	logic wstrb0_q;

	wire aw_take = S_AXI_AWVALID_I & awready_q;
	wire w_take = S_AXI_WVALID_I & wready_q;
	wire wr_fire = aw_full_q & w_full_q & ~bvalid_q;
	wire b_done = bvalid_q & S_AXI_BREADY_I;
	wire aw_full_d = aw_take | (aw_full_q & ~wr_fire);
	wire w_full_d = w_take | (w_full_q & ~wr_fire);

	wire hw_sc = aw_idx_q == (ADDR_W-2)'(`IDX_SERIAL_CTRL);
	wire hw_dp = aw_idx_q == (ADDR_W-2)'(`IDX_DEV_PROTECT);
	wire hw_rc = aw_idx_q == (ADDR_W-2)'(`IDX_RESET_CAUSE);
	wire hw_ir = aw_idx_q == (ADDR_W-2)'(`IDX_IRQ_ROUTE);
	wire hw_ro = aw_idx_q == (ADDR_W-2)'(`IDX_REAR_IO);
	wire hw_any = hw_sc | hw_dp | hw_rc | hw_ir | hw_ro;
	// only byte lane 0 carries register bits
	wire wr_ok = wr_fire & wstrb0_q;
	wire wr_sc = wr_ok & hw_sc;
	wire wr_dp = wr_ok & hw_dp;
	wire wr_rc = wr_ok & hw_rc;
	wire wr_ir = wr_ok & hw_ir;
	axi_resp_t wresp;
	assign wresp = hw_any ? `RESP_OKAY : `RESP_SLVERR;

	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
		end else begin
			aw_full_q <= aw_full_d;
			w_full_q <= w_full_d;
			awready_q <= ~aw_full_d;
			wready_q <= ~w_full_d;
		end
	end

	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			aw_idx_q <= '0;
			wdata_q <= 8'h00;
			wstrb0_q <= 1'b0;
		end else begin
			if (aw_take) begin
				aw_idx_q <= S_AXI_AWADDR_I[ADDR_W-1:2];
			end
			if (w_take) begin
				wdata_q <= S_AXI_WDATA_I[7:0];
				wstrb0_q <= S_AXI_WSTRB_I[0];
			end
		end
	end

	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			bvalid_q <= 1'b0;
			bresp_q <= `RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			bresp_q <= wresp;
		end else if (b_done) begin
			bvalid_q <= 1'b0;
		end
	end

	// --------------------------------------------------------------
	// device protect latches
	// --------------------------------------------------------------
	protect_t prot_q;
	protect_t prot_set;
	// writing zero never clears; only power-on reset does
	assign prot_set = wr_dp ? wdata_q[2:0] : 3'h0;

	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			prot_q <= `RST_PROTECT;
		end else begin
			prot_q <= prot_q | prot_set;
		end
	end

	// --------------------------------------------------------------
	// reset cause flags
	// --------------------------------------------------------------
	logic cold_q;
	logic [2:0] cause_q;
	logic [2:0] cause_set;
	logic [2:0] cause_clr;
	wire cold_clr = wr_rc & wdata_q[`BIT_COLD];

	// sources are levels; the flag sets while held, set beats clear
	assign cause_set = {sync2_q[S_PANEL], backplane_reset_in, sync2_q[S_WDRST]};
	assign cause_clr = wr_rc ? wdata_q[2:0] : 3'h0;

	// warm reset is not wired here so the cause survives it
	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			cold_q <= `RST_COLD;
			cause_q <= `RST_CAUSE;
		end else begin
			cold_q <= cold_q & ~cold_clr;
			cause_q <= cause_set | (cause_q & ~cause_clr);
		end
	end

	// --------------------------------------------------------------
	// interrupt routing and serial route control
	// --------------------------------------------------------------
	logic uart_irq_enable_q;
	logic [2:0] src_en_q;
	wd_route_t watchdog_irq_route_q;
	logic serial_a_route_q;
	localparam logic SERIAL_RST = FRONT_IO_BUILD;

	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			uart_irq_enable_q <= `RST_UART_EN;
			src_en_q <= `RST_SRC_EN;
			watchdog_irq_route_q <= `RST_WD_ROUTE;
			serial_a_route_q <= SERIAL_RST;
		end else if (warm) begin
			uart_irq_enable_q <= `RST_UART_EN;
			src_en_q <= `RST_SRC_EN;
			watchdog_irq_route_q <= `RST_WD_ROUTE;
			serial_a_route_q <= SERIAL_RST;
		end else begin
			if (wr_ir) begin
				uart_irq_enable_q <= wdata_q[`BIT_UART_EN];
				src_en_q <= wdata_q[`BIT_PFAIL_EN:`BIT_DERATE_EN];
				watchdog_irq_route_q <= wdata_q[`WD_ROUTE_HI:`WD_ROUTE_LO];
			end
			if (wr_sc) begin
				serial_a_route_q <= wdata_q[`BIT_SERIAL_A];
			end
		end
	end

	wire pfail_en = src_en_q[2];
	wire enum_en = src_en_q[1];
	wire derate_en = src_en_q[0];
	// reserved route codes leave the watchdog unrouted
	wire wd_to_irq5 = (watchdog_irq_route_q == `WD_ROUTE_IRQ5) & WATCHDOG_IRQ_I;
	wire irq5_any = (pfail_en & power_fail_in)
		| (enum_en & enum_in)
		| (derate_en & derate_in)
		| wd_to_irq5;

	logic irq3_q;
	logic irq4_q;
	logic irq5_q;

	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			irq3_q <= 1'b0;
			irq4_q <= 1'b0;
			irq5_q <= 1'b0;
		end else begin
			irq3_q <= uart_irq_enable_q & UART_IRQ3_I;
			irq4_q <= uart_irq_enable_q & UART_IRQ4_I;
			irq5_q <= irq5_any;
		end
	end

	// --------------------------------------------------------------
	// axi read channel
	// --------------------------------------------------------------
	logic arready_q;
	logic rvalid_q;
	reg_byte_t rdata_q;
	axi_resp_t rresp_q;

	wire ar_take = S_AXI_ARVALID_I & arready_q;
	wire r_done = rvalid_q & S_AXI_RREADY_I;
	wire rvalid_d = ar_take | (rvalid_q & ~r_done);
	wire [ADDR_W-3:0] ar_idx = S_AXI_ARADDR_I[ADDR_W-1:2];
	wire hr_sc = ar_idx == (ADDR_W-2)'(`IDX_SERIAL_CTRL);
	wire hr_dp = ar_idx == (ADDR_W-2)'(`IDX_DEV_PROTECT);
	wire hr_rc = ar_idx == (ADDR_W-2)'(`IDX_RESET_CAUSE);
	wire hr_ir = ar_idx == (ADDR_W-2)'(`IDX_IRQ_ROUTE);
	wire hr_ro = ar_idx == (ADDR_W-2)'(`IDX_REAR_IO);
	wire hr_any = hr_sc | hr_dp | hr_rc | hr_ir | hr_ro;

	reg_byte_t sc_val;
	reg_byte_t dp_val;
	reg_byte_t rc_val;
	reg_byte_t ir_val;
	reg_byte_t ro_val;
	reg_byte_t rd_byte;
	assign sc_val = {5'h00, serial_a_route_q, 2'h0};
	assign dp_val = {sys_protect_mirror, 4'h0, prot_q};
	assign rc_val = {cold_q, 4'h0, cause_q};
	assign ir_val = {uart_irq_enable_q, src_en_q, 2'h0, watchdog_irq_route_q};
	assign ro_val = {2'h0, rear_io_config, 4'h0};
	assign rd_byte = ({8{hr_sc}} & sc_val) | ({8{hr_dp}} & dp_val)
		| ({8{hr_rc}} & rc_val) | ({8{hr_ir}} & ir_val) | ({8{hr_ro}} & ro_val);

	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= 8'h00;
			rresp_q <= `RESP_OKAY;
		end else begin
			arready_q <= ~rvalid_d;
			rvalid_q <= rvalid_d;
			if (ar_take) begin
				rdata_q <= rd_byte;
				rresp_q <= hr_any ? `RESP_OKAY : `RESP_SLVERR;
			end
		end
	end

	// --------------------------------------------------------------
	// outputs
	// --------------------------------------------------------------
	assign S_AXI_AWREADY_O = awready_q;
	assign S_AXI_WREADY_O = wready_q;
	assign S_AXI_BVALID_O = bvalid_q;
	assign S_AXI_BRESP_O = bresp_q;
	assign S_AXI_ARREADY_O = arready_q;
	assign S_AXI_RVALID_O = rvalid_q;
	assign S_AXI_RDATA_O = {24'h000000, rdata_q};
	assign S_AXI_RRESP_O = rresp_q;
	assign SSD_PROTECT_O = prot_q[`BIT_SSD];
	assign EEPROM_PROTECT_O = prot_q[`BIT_EEPROM];
	assign BOOT_FLASH_PROTECT_O = prot_q[`BIT_BOOT];
	assign IRQ3_O = irq3_q;
	assign IRQ4_O = irq4_q;
	assign IRQ5_O = irq5_q;
	assign SERIAL_A_ROUTE_O = serial_a_route_q;

	// --------------------------------------------------------------
	// assertions
	// --------------------------------------------------------------
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (RST_I);

	mirror_read_a: assert property (
		ar_take && hr_dp |=> S_AXI_RDATA_O[7] == !$past(sync2_q[S_SYSP]))
		else $error("protect read bit 7 does not mirror system protect");
	ssd_latch_hold_a: assert property (
		prot_q[`BIT_SSD] |=> prot_q[`BIT_SSD] [*3])
		else $error("ssd protect latch cleared");
	eeprom_set_a: assert property (
		wr_dp && wdata_q[`BIT_EEPROM] |=> prot_q[`BIT_EEPROM])
		else $error("eeprom protect not set by write of one");
	boot_no_clear_a: assert property (
		wr_dp && !wdata_q[`BIT_BOOT] && prot_q[`BIT_BOOT] |=> prot_q[`BIT_BOOT])
		else $error("boot flash protect cleared by write of zero");
	protect_pin_a: assert property (
		wr_dp && wdata_q[`BIT_SSD] |=> SSD_PROTECT_O ##1 SSD_PROTECT_O)
		else $error("ssd protect output not driven after set");
	cold_clear_a: assert property (
		cold_clr |=> !cold_q ##1 !cold_q)
		else $error("cold flag not cleared by write of one");
	panel_set_a: assert property (
		sync2_q[S_PANEL] |=> cause_q[`BIT_PANEL])
		else $error("panel reset flag not set");
	backplane_set_a: assert property (
		backplane_reset_in && wr_rc && wdata_q[`BIT_BACKPLANE] |=> cause_q[`BIT_BACKPLANE])
		else $error("backplane flag lost to a simultaneous clear");
	watchdog_keep_a: assert property (
		cause_q[`BIT_WATCHDOG] && !wr_rc |=> cause_q[`BIT_WATCHDOG])
		else $error("watchdog flag dropped without a clear");
	warm_keeps_a: assert property (
		warm && !wr_rc && !(|cause_set) |=> $stable(rc_val))
		else $error("warm reset altered reset cause flags");
	uart_gate_a: assert property (
		!uart_irq_enable_q |=> !IRQ3_O && !IRQ4_O)
		else $error("uart interrupt passed while disabled");
	pfail_route_a: assert property (
		pfail_en && power_fail_in |=> IRQ5_O)
		else $error("enabled power fail did not raise irq5");
	enum_route_a: assert property (
		enum_en && enum_in |=> IRQ5_O)
		else $error("enabled enumeration did not raise irq5");
	derate_route_a: assert property (
		derate_en && derate_in |=> IRQ5_O)
		else $error("enabled derating did not raise irq5");
	wd_reserved_a: assert property (
		watchdog_irq_route_q != `WD_ROUTE_IRQ5 && !(|(src_en_q & {power_fail_in,
		enum_in, derate_in})) |=> !IRQ5_O)
		else $error("irq5 raised with no routed source");
	rear_read_a: assert property (
		ar_take && hr_ro |=> S_AXI_RDATA_O[5:4] == $past(rear_io_config))
		else $error("rear io status does not show straps");
	route_warm_a: assert property (
		warm |=> SERIAL_A_ROUTE_O == SERIAL_RST)
		else $error("serial route not restored to build default");
	route_write_a: assert property (
		wr_sc && !warm |=> SERIAL_A_ROUTE_O == $past(wdata_q[`BIT_SERIAL_A]))
		else $error("serial route write not applied");

	protect_write_c: cover property (wr_dp && wdata_q[`BIT_SSD]);
	cause_read_c: cover property (ar_take && hr_rc ##1 rvalid_q);
	irq5_raise_c: cover property (!IRQ5_O ##1 IRQ5_O);
	data_first_c: cover property (w_take && !aw_take && !aw_full_q);

endmodule : board_protect_reset_irq_regs

// [verification/tb_top.sv]
// self-checking bench for the board register group
`timescale 1ns/1ps
`include "board_regs.svh"

module tb_top;
	import board_pkg::*;

	typedef struct {
		logic wr;
		logic [11:0] a;
		logic [7:0] d;
		logic [7:0] e;
		axi_resp_t rs;
	} row_t;

	localparam logic [11:0] A_SER = {`IDX_SERIAL_CTRL, 2'h0};
	localparam logic [11:0] A_PROT = {`IDX_DEV_PROTECT, 2'h0};
	localparam logic [11:0] A_CAUSE = {`IDX_RESET_CAUSE, 2'h0};
	localparam logic [11:0] A_ROUTE = {`IDX_IRQ_ROUTE, 2'h0};
	localparam logic [11:0] A_REAR = {`IDX_REAR_IO, 2'h0};
	localparam logic [11:0] A_BAD = 12'ha20;

	logic clk = 1'h0;
	logic rst = 1'h1;
	logic warm = 1'h0;
	logic [11:0] awaddr = 12'h0;
	logic [11:0] araddr = 12'h0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic sys_n = 1'h1;
	logic [2:0] cause_pins = 3'h0;
	logic [2:0] src_n = 3'h7;
	rear_cfg_t rear = 2'h3;
	logic uart3 = 1'h0, uart4 = 1'h0, wd_irq = 1'h0;
	logic awready, wready, bvalid, arready, rvalid;
	logic ssd_p, ee_p, boot_p, irq3, irq4, irq5, ser_route;
	axi_resp_t bresp, rresp, resp;
	logic [31:0] rdata, got;
	int n_errors = 0;
	int checks_done = 0;
	row_t rows [15];

	always #12.5 clk = ~clk;

	board_protect_reset_irq_regs #(.ADDR_W(12), .FRONT_IO_BUILD(1'b0)) dut_u (
		.CORE_CLK_I(clk), .RST_I(rst), .WARM_RST_I(warm),
		.S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
		.S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
		.S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
		.S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
		.S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
		.S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .SYS_PROTECT_N_I(sys_n),
		.PANEL_RESET_I(cause_pins[2]), .BACKPLANE_RESET_I(cause_pins[1]),
		.WATCHDOG_RESET_I(cause_pins[0]), .POWER_FAIL_N_I(src_n[2]), .ENUM_N_I(src_n[1]),
		.DERATE_N_I(src_n[0]), .REAR_IO_CONFIG_I(rear), .UART_IRQ3_I(uart3),
		.UART_IRQ4_I(uart4), .WATCHDOG_IRQ_I(wd_irq), .SSD_PROTECT_O(ssd_p),
		.EEPROM_PROTECT_O(ee_p), .BOOT_FLASH_PROTECT_O(boot_p), .IRQ3_O(irq3),
		.IRQ4_O(irq4), .IRQ5_O(irq5), .SERIAL_A_ROUTE_O(ser_route)
	);

	// --------------------------------------------------------------
	// compare, bus and closing tasks
	// --------------------------------------------------------------
	task automatic cmp_data(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value at %0t: data %h expected %h", $time, g, e);
		end
	endtask : cmp_data

	task automatic cmp_resp(input axi_resp_t g, input axi_resp_t e);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value at %0t: resp %h expected %h", $time, g, e);
		end
	endtask : cmp_resp

	task automatic cmp_pin(input logic g, input logic e);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value at %0t: pin %h expected %h", $time, g, e);
		end
	endtask : cmp_pin

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	// payload held until each channel's own ready is seen at an edge
	task automatic axi_write(input logic [11:0] a, input logic [7:0] d, output axi_resp_t r);
		@(posedge clk);
		awaddr <= a;
		awvalid <= 1'h1;
		wdata <= {24'h0, d};
		wstrb <= 4'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'h0;
			if (wvalid && wready) wvalid <= 1'h0;
		end while (bvalid !== 1'h1);
		r = bresp;
		bready <= 1'h0;
	endtask : axi_write

	task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output axi_resp_t r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'h0;
		end while (rvalid !== 1'h1);
		d = rdata;
		r = rresp;
		rready <= 1'h0;
	endtask : axi_read

	task automatic wr_ok(input logic [11:0] a, input logic [7:0] d);
		axi_write(a, d, resp);
		cmp_resp(resp, `RESP_OKAY);
	endtask : wr_ok

	task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
		axi_read(a, got, resp);
		cmp_data(got, {24'h0, e});
	endtask : rd_chk

	task automatic give_verdict;
		$display("comparisons %0d, mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : give_verdict

	// whole run is a few hundred cycles; a hang stops here
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		give_verdict();
	end

	// --------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------
	initial begin
		rows = '{'{1'h0, A_PROT, 8'h00, 8'h00, `RESP_OKAY}, '{1'h0, A_CAUSE, 8'h00, 8'h80, `RESP_OKAY},
			'{1'h0, A_ROUTE, 8'h00, 8'h80, `RESP_OKAY}, '{1'h0, A_REAR, 8'h00, 8'h30, `RESP_OKAY},
			'{1'h0, A_SER, 8'h00, 8'h00, `RESP_OKAY}, '{1'h1, A_BAD, 8'h55, 8'h00, `RESP_SLVERR},
			'{1'h1, A_PROT, 8'h02, 8'h02, `RESP_OKAY}, '{1'h1, A_PROT, 8'h00, 8'h02, `RESP_OKAY},
			'{1'h1, A_PROT, 8'hff, 8'h07, `RESP_OKAY}, '{1'h1, A_CAUSE, 8'h00, 8'h80, `RESP_OKAY},
			'{1'h1, A_CAUSE, 8'h80, 8'h00, `RESP_OKAY}, '{1'h1, A_ROUTE, 8'hff, 8'hf3, `RESP_OKAY},
			'{1'h1, A_ROUTE, 8'h02, 8'h02, `RESP_OKAY}, '{1'h1, A_SER, 8'hff, 8'h04, `RESP_OKAY},
			'{1'h1, A_REAR, 8'hff, 8'h30, `RESP_OKAY}};
		repeat (12) @(posedge clk);
		rst <= 1'h0;
		tick(2);
		cmp_pin(ssd_p | ee_p | boot_p, 1'h0);
		cmp_pin(ser_route, 1'h0);
		foreach (rows[i]) begin
			if (rows[i].wr) begin
				axi_write(rows[i].a, rows[i].d, resp);
				cmp_resp(resp, rows[i].rs);
			end
			axi_read(rows[i].a, got, resp);
			cmp_data(got, {24'h0, rows[i].e});
			cmp_resp(resp, rows[i].rs);
		end
		cmp_pin(ssd_p & ee_p & boot_p, 1'h1);
		cmp_pin(ser_route, 1'h1);
		// cause pins are levels; the flag must outlive the pin
		for (int i = 0; i < 3; i++) begin
			@(posedge clk);
			cause_pins[i] <= 1'h1;
			tick(4);
			@(posedge clk);
			cause_pins[i] <= 1'h0;
			tick(4);
			rd_chk(A_CAUSE, 8'((2 << i) - 1));
		end
		wr_ok(A_CAUSE, 8'h05);
		rd_chk(A_CAUSE, 8'h02);
		@(posedge clk);
		warm <= 1'h1;
		tick(6);
		@(posedge clk);
		warm <= 1'h0;
		tick(4);
		rd_chk(A_CAUSE, 8'h02);
		rd_chk(A_ROUTE, 8'h80);
		rd_chk(A_SER, 8'h00);
		cmp_pin(ser_route, 1'h0);
		// a clear that meets a held source loses to the set
		@(posedge clk);
		cause_pins[1] <= 1'h1;
		tick(4);
		wr_ok(A_CAUSE, 8'h02);
		rd_chk(A_CAUSE, 8'h02);
		@(posedge clk);
		cause_pins[1] <= 1'h0;
		tick(4);
		wr_ok(A_CAUSE, 8'h02);
		rd_chk(A_CAUSE, 8'h00);
		@(posedge clk);
		sys_n <= 1'h0;
		tick(4);
		rd_chk(A_PROT, 8'h87);
		@(posedge clk);
		sys_n <= 1'h1;
		tick(4);
		rd_chk(A_PROT, 8'h07);
		for (int v = 0; v < 4; v++) begin
			@(posedge clk);
			rear <= 2'(v);
			tick(4);
			rd_chk(A_REAR, 8'(v << 4));
		end
		@(posedge clk);
		uart3 <= 1'h1;
		uart4 <= 1'h1;
		wd_irq <= 1'h1;
		tick(2);
		cmp_pin(irq3 & irq4, 1'h1);
		cmp_pin(irq5, 1'h0);
		for (int r = 0; r < 4; r++) begin
			wr_ok(A_ROUTE, 8'(r));
			tick(2);
			cmp_pin(irq3 | irq4, 1'h0);
			cmp_pin(irq5, r == 1);
		end
		@(posedge clk);
		wd_irq <= 1'h0;
		wr_ok(A_ROUTE, 8'h70);
		for (int i = 0; i < 3; i++) begin
			@(posedge clk);
			src_n[i] <= 1'h0;
			tick(3);
			cmp_pin(irq5, 1'h1);
			@(posedge clk);
			src_n[i] <= 1'h1;
			tick(4);
			cmp_pin(irq5, 1'h0);
		end
		wr_ok(A_ROUTE, 8'h00);
		@(posedge clk);
		src_n <= 3'h0;
		tick(4);
		cmp_pin(irq5, 1'h0);
		@(posedge clk);
		src_n <= 3'h7;
		rst <= 1'h1;
		tick(3);
		cmp_pin(ssd_p | ee_p | boot_p, 1'h0);
		@(posedge clk);
		rst <= 1'h0;
		tick(2);
		rd_chk(A_CAUSE, 8'h80);
		rd_chk(A_PROT, 8'h00);
		// each latch must reach its own pin; a zero write keeps boot set
		wr_ok(A_PROT, 8'h01);
		wr_ok(A_PROT, 8'h04);
		tick(1);
		cmp_pin(boot_p & ssd_p, 1'h1);
		cmp_pin(ee_p, 1'h0);
		rd_chk(A_PROT, 8'h05);
		give_verdict();
	end
endmodule : tb_top
